// ### sar_ctrl_pkg.sv
// shared constants, types and register map of the converter control block
// assumes a single 200 MHz clock domain and a synchronous active-high reset
package sar_ctrl_pkg;
    localparam int          RES_W         = 18;
    localparam int          CLK_PERIOD_PS = 5000;
    // acquisition window, in ns
    localparam int          ACQ_NS        = 250;
    localparam int          ACQ_CYC       = (ACQ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          ACQ_CNT_W     = $clog2(ACQ_CYC + 1);
    localparam logic [4:0]  SAR_TOP_BIT   = 5'h11;

    // register map, byte addresses
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_STATUS    = 4'h4;
    localparam logic [3:0]  REG_RESULT    = 4'h8;
    localparam int          CTRL_INHIBIT  = 0;
    localparam logic        CTRL_RST      = 1'h0;
    localparam int          STAT_BUSY     = 0;
    localparam int          STAT_LOWPWR   = 1;
    localparam int          STAT_ARMED    = 2;
    localparam int          STAT_REFBUF   = 3;

    // bus formats
    localparam logic [1:0]  FMT_PAR18     = 2'h0;
    localparam logic [1:0]  FMT_WORD16    = 2'h1;
    localparam logic [1:0]  FMT_BYTE8     = 2'h2;
    localparam logic [1:0]  FMT_SERIAL    = 2'h3;

    typedef enum logic [2:0] {
        ST_ACQ   = 3'h1,
        ST_ARMED = 3'h2,
        ST_CONV  = 3'h4
    } conv_state_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        write;
        logic        read;
    } reg_req_t;
endpackage

// ### sar_conv_ctrl.sv
// conversion sequencer, successive approximation logic and parallel bus multiplexer
// assumes all control pins are asynchronous and the comparator output is on this clock
`timescale 1ns/1ps
module sar_conv_ctrl
    import sar_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              reset,
    // control pins
    input  wire logic              convert_start_n,
    input  wire logic              power_down_in,
    input  wire logic              refbuf_disable,
    input  wire logic              bus_format_sel_lo,
    input  wire logic              bus_format_sel_hi,
    input  wire logic              cs_n,
    input  wire logic              rd_n,
    // data pins
    input  wire logic [RES_W-1:0]  data_in,
    output logic      [RES_W-1:0]  data_out,
    output logic      [RES_W-1:0]  data_oe,
    // status pins
    output logic                   busy,
    output logic                   low_power,
    output logic                   refbuf_enable,
    // analog core
    input  wire logic              comp_in,
    output logic                   sample_hold,
    output logic      [RES_W-1:0]  dac_code,
    // register port
    input  wire reg_req_t          reg_req,
    output logic      [31:0]       reg_rdata
);
    localparam int SYNC_W = 10;

    // two-stage synchroniser for every control pin input and data_in[2:0]
    logic [SYNC_W-1:0] sync1_r, sync2_r, sync1_nxt;
    logic              convert_start_n_d_r;
    logic              convert_start_n_s, pd_s, refbuf_off_s, cs_s, rd_s;
    logic [1:0]        fmt_s;
    logic              code_fmt_s, word_sel_s, byte_sel_s;

    assign sync1_nxt = {convert_start_n, power_down_in, refbuf_disable, bus_format_sel_hi,
                        bus_format_sel_lo, cs_n, rd_n, data_in[2:0]};
    assign {convert_start_n_s, pd_s, refbuf_off_s, fmt_s, cs_s, rd_s,
            byte_sel_s, word_sel_s, code_fmt_s} = sync2_r;

    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_r   <= 10'h298;
            sync2_r   <= 10'h298;
            convert_start_n_d_r <= 1'h1;
        end else begin
            sync1_r   <= sync1_nxt;
            sync2_r   <= sync1_r;
            convert_start_n_d_r <= convert_start_n_s;
        end
    end

    // sequencer state
    conv_state_t            state_r, state_nxt;
    logic [ACQ_CNT_W-1:0]   acq_cnt_r, acq_cnt_nxt;
    logic [4:0]             bit_r, bit_nxt;
    logic [RES_W-1:0]       sar_r, sar_nxt, result_r, result_nxt, decision;
    logic                   inhibit_r, inhibit_nxt;
    logic                   busy_r, busy_nxt, lowpwr_r, lowpwr_nxt, refbuf_r, refbuf_nxt;
    logic                   blocked, convert_start_n_fall, acq_done;

    assign blocked    = pd_s | inhibit_r;
    assign convert_start_n_fall = convert_start_n_d_r & ~convert_start_n_s;
    assign acq_done   = (acq_cnt_r == ACQ_CNT_W'(ACQ_CYC - 1));

    function automatic logic [RES_W-1:0] bit_mask(input logic [4:0] idx);
        bit_mask = RES_W'(1) << idx;
    endfunction

    always_comb begin
        state_nxt   = state_r;
        acq_cnt_nxt = acq_cnt_r;
        bit_nxt     = bit_r;
        sar_nxt     = sar_r;
        result_nxt  = result_r;
        decision    = comp_in ? sar_r : (sar_r & ~bit_mask(bit_r));
        case (state_r)
            ST_ACQ: begin
                if (!acq_done) begin
                    acq_cnt_nxt = acq_cnt_r + ACQ_CNT_W'(1);
                end else if (!convert_start_n_s && !blocked) begin
                    state_nxt = ST_CONV;
                    bit_nxt   = SAR_TOP_BIT;
                    sar_nxt   = bit_mask(SAR_TOP_BIT);
                end else if (convert_start_n_s) begin
                    state_nxt = ST_ARMED;
                end
            end
            ST_ARMED: begin
                // start on falling edge, unless blocked
                if (convert_start_n_fall && !blocked) begin
                    state_nxt = ST_CONV;
                    bit_nxt   = SAR_TOP_BIT;
                    sar_nxt   = bit_mask(SAR_TOP_BIT);
                end
            end
            ST_CONV: begin
                if (bit_r == 5'h0) begin
                    result_nxt  = decision;
                    state_nxt   = ST_ACQ;
                    acq_cnt_nxt = '0;
                end else begin
                    bit_nxt = bit_r - 5'h1;
                    sar_nxt = decision | bit_mask(bit_r - 5'h1);
                end
            end
            default: begin
                state_nxt   = ST_ACQ;
                acq_cnt_nxt = '0;
            end
        endcase
        busy_nxt    = (state_nxt == ST_CONV);
        lowpwr_nxt  = pd_s && (state_nxt != ST_CONV);
        refbuf_nxt  = ~refbuf_off_s;
        inhibit_nxt = inhibit_r;
        if (reg_req.write && reg_req.addr == REG_CTRL) begin
            inhibit_nxt = reg_req.wdata[CTRL_INHIBIT];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_r   <= ST_ACQ;
            acq_cnt_r <= '0;
            bit_r     <= 5'h0;
            sar_r     <= '0;
            result_r  <= '0;
            inhibit_r <= CTRL_RST;
            busy_r    <= 1'h0;
            lowpwr_r  <= 1'h0;
            refbuf_r  <= 1'h0;
        end else begin
            state_r   <= state_nxt;
            acq_cnt_r <= acq_cnt_nxt;
            bit_r     <= bit_nxt;
            sar_r     <= sar_nxt;
            result_r  <= result_nxt;
            inhibit_r <= inhibit_nxt;
            busy_r    <= busy_nxt;
            lowpwr_r  <= lowpwr_nxt;
            refbuf_r  <= refbuf_nxt;
        end
    end

    assign busy          = busy_r;
    assign sample_hold   = busy_r;
    assign dac_code      = sar_r;
    assign low_power     = lowpwr_r;
    assign refbuf_enable = refbuf_r;

    // parallel bus multiplexer
    logic [RES_W-1:0] dout_r, dout_nxt, doe_r, doe_nxt, coded;
    logic             rd_en;

    assign rd_en = ~cs_s & ~rd_s;

    always_comb begin
        // two's complement flips the sign bit
        coded    = code_fmt_s ? result_r : {~result_r[RES_W-1], result_r[RES_W-2:0]};
        dout_nxt = '0;
        doe_nxt  = '0;
        case (fmt_s)
            FMT_PAR18: begin
                dout_nxt = result_r;
                doe_nxt  = '1;
            end
            FMT_WORD16: begin
                doe_nxt = 18'h3fffc;
                if (!word_sel_s) begin
                    dout_nxt[17:2] = coded[17:2];
                end else begin
                    dout_nxt[3:2] = coded[1:0];
                end
            end
            FMT_BYTE8: begin
                doe_nxt = 18'h3fc00;
                if (!word_sel_s && !byte_sel_s) begin
                    dout_nxt[17:10] = coded[17:10];
                end else if (!word_sel_s) begin
                    dout_nxt[17:10] = coded[9:2];
                end else if (!byte_sel_s) begin
                    dout_nxt[11:10] = coded[1:0];
                end else begin
                    dout_nxt[17:16] = coded[1:0];
                end
            end
            default: doe_nxt = '0;
        endcase
        if (!rd_en) begin
            doe_nxt = '0;
        end
    end

    // register read port
    logic [31:0] rdata_r, rdata_nxt;

    always_comb begin
        rdata_nxt = 32'h0;
        if (reg_req.read) begin
            case (reg_req.addr)
                REG_CTRL: rdata_nxt[CTRL_INHIBIT] = inhibit_r;
                REG_STATUS: begin
                    rdata_nxt[STAT_BUSY]   = busy_r;
                    rdata_nxt[STAT_LOWPWR] = lowpwr_r;
                    rdata_nxt[STAT_ARMED]  = (state_r == ST_ARMED);
                    rdata_nxt[STAT_REFBUF] = refbuf_r;
                end
                REG_RESULT: rdata_nxt[RES_W-1:0] = result_r;
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            dout_r  <= '0;
            doe_r   <= '0;
            rdata_r <= 32'h0;
        end else begin
            dout_r  <= dout_nxt;
            doe_r   <= doe_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign data_out  = dout_r;
    assign data_oe   = doe_r;
    assign reg_rdata = rdata_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence acq_end_low;
        state_r == ST_ACQ && acq_done && !convert_start_n_s && !blocked;
    endsequence
    sequence full_conversion;
        busy_r [*8] ##1 busy_r [*8] ##1 busy_r [*2] ##1 !busy_r;
    endsequence

    a_reset_abort: assert property (disable iff (1'b0) reset |=> state_r == ST_ACQ && !busy_r)
        else $error("reset did not abort conversion");
    a_pd_blocks: assert property (state_r != ST_CONV && blocked |=> state_r != ST_CONV)
        else $error("conversion started while blocked");
    a_conv_finishes: assert property (state_r == ST_CONV && bit_r != 5'h0 |=> state_r == ST_CONV)
        else $error("conversion cut short");
    a_edge_start: assert property (state_r == ST_ARMED && convert_start_n_fall && !blocked |=> busy_r)
        else $error("falling edge did not start conversion");
    a_armed_waits: assert property (state_r == ST_ARMED && !convert_start_n_fall |=> !busy_r)
        else $error("conversion started without an edge");
    a_immediate_start: assert property (acq_end_low |=> busy_r)
        else $error("low convert start did not start at once");
    a_refbuf_follow: assert property (refbuf_off_s ##1 refbuf_off_s |-> !refbuf_r)
        else $error("reference buffer not off");
    a_par18_bus: assert property (fmt_s == FMT_PAR18 && rd_en |=> dout_r == $past(result_r))
        else $error("18-bit bus mismatch");
    a_word_low: assert property (fmt_s == FMT_WORD16 && word_sel_s && rd_en |=>
                                 dout_r[3:2] == $past(coded[1:0]) && dout_r[17:4] == 14'h0)
        else $error("low word mismatch");
    a_byte_float: assert property (fmt_s == FMT_BYTE8 |=> doe_r[9:0] == 10'h0)
        else $error("byte format drives low pins");
    a_twos_comp: assert property (fmt_s == FMT_WORD16 && !word_sel_s && !code_fmt_s && rd_en
                                  |=> dout_r[17] == !$past(result_r[17]))
        else $error("sign bit not inverted");
    a_busy_span: assert property ($rose(busy_r) |-> full_conversion)
        else $error("busy length wrong");
    a_busy_result: assert property ($fell(busy_r) |-> result_r == $past(decision))
        else $error("result not latched at busy fall");
    a_drive_gate: assert property (!rd_en |=> doe_r == '0)
        else $error("bus driven outside read");
endmodule // sar_conv_ctrl

// ### adc_far_model.sv
// comparator and pin-level model on the far side of the converter control block
// assumes dac_code and the data pins settle within one clock of the same domain
`timescale 1ns/1ps
module adc_far_model
    import sar_ctrl_pkg::*;
(
    // analog side
    input  wire logic [RES_W-1:0] target,
    input  wire logic [RES_W-1:0] dac_code,
    output logic                  comp_in,
    // data pins
    input  wire logic [RES_W-1:0] data_out,
    input  wire logic [RES_W-1:0] data_oe,
    input  wire logic [RES_W-1:0] host_pins,
    output logic      [RES_W-1:0] data_in
);
    // keep a trial bit while the trial does not exceed the held input
    assign comp_in = (dac_code <= target);
    // host drives select pins only where the block does not
    assign data_in = (data_out & data_oe) | (host_pins & ~data_oe);
endmodule // adc_far_model

// ### testbench.sv
// self-checking bench for the converter control block
// assumes the far-side model answers the trial code within the same cycle
`timescale 1ns/1ps
module testbench
    import sar_ctrl_pkg::*;
;
    logic             clock = 1'b0;
    logic             reset = 1'b1;
    logic             convert_start_n = 1'b0;
    logic             power_down_in = 1'b0;
    logic             refbuf_disable = 1'b0;
    logic             bus_format_sel_lo = 1'b0;
    logic             bus_format_sel_hi = 1'b0;
    logic             cs_n = 1'b1;
    logic             rd_n = 1'b1;
    logic [RES_W-1:0] host_pins = 18'h0;
    logic [RES_W-1:0] target = 18'h2a5c3;
    reg_req_t         reg_req = '0;
    logic [RES_W-1:0] data_in, data_out, data_oe, dac_code;
    logic             busy, low_power, refbuf_enable, comp_in, sample_hold;
    logic [31:0]      reg_rdata;
    int               num_errors = 0;
    int               comparisons = 0;
    int               cycles = 0;

    sar_conv_ctrl dut (
        .clock, .reset, .convert_start_n, .power_down_in, .refbuf_disable,
        .bus_format_sel_lo, .bus_format_sel_hi, .cs_n, .rd_n, .data_in, .data_out,
        .data_oe, .busy, .low_power, .refbuf_enable, .comp_in, .sample_hold,
        .dac_code, .reg_req, .reg_rdata
    );
    adc_far_model far (
        .target, .dac_code, .comp_in, .data_out, .data_oe, .host_pins, .data_in
    );

    always #2.5 clock = ~clock;

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock) reg_req <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
        @(posedge clock) reg_req <= '0;
        #1 d = reg_rdata;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock) reg_req <= '{addr: a, wdata: v, write: 1'b1, read: 1'b0};
        @(posedge clock) reg_req <= '0;
    endtask

    // waits up to n cycles for busy to reach lvl, k counts the cycles taken
    task automatic wait_busy(input logic lvl, input int n, output int k);
        k = 0;
        #1;
        while (busy !== lvl && k < n) begin
            @(posedge clock);
            #1 k++;
        end
    endtask

    // expected {oe, data} of the parallel pins for the stored result
    function automatic logic [35:0] exp_bus(input logic [1:0] f, input logic w, b, c);
        logic [17:0] r, d, oe;
        r = target;
        if (f != FMT_PAR18 && !c) r[17] = ~r[17];
        d = 18'h0;
        oe = 18'h0;
        case (f)
            FMT_PAR18: begin oe = 18'h3ffff; d = target; end
            FMT_WORD16: begin
                oe = 18'h3fffc;
                d = w ? {14'h0, r[1:0], 2'h0} : {r[17:2], 2'h0};
            end
            FMT_BYTE8: begin
                oe = 18'h3fc00;
                d[17:10] = !w ? (b ? r[9:2] : r[17:10]) : (b ? {r[1:0], 6'h0} : {6'h0, r[1:0]});
            end
            default: ;
        endcase
        return {oe, d};
    endfunction

    initial begin
        logic [31:0] d;
        logic [35:0] e;
        int          k;
        cyc(11);
        @(posedge clock) reset <= 1'b0;
        #1 check("busy after reset", busy, 32'h0);
        reg_rd(4'hc, d); check("unmapped read", d, 32'h0);
        reg_wr(REG_CTRL, 32'h1); reg_rd(REG_CTRL, d); check("ctrl", d, 32'h1);
        reg_wr(REG_CTRL, 32'h0);
        #1 check("refbuf on", refbuf_enable, 32'h1);
        @(posedge clock) refbuf_disable <= 1'b1;
        cyc(4); #1 check("refbuf off", refbuf_enable, 32'h0);
        @(posedge clock) refbuf_disable <= 1'b0;
        wait_busy(1'b1, 80, k); check("start on low level", busy, 32'h1);
        check("first trial code", dac_code, 32'h20000);
        wait_busy(1'b0, 30, k); check("busy length", k, 32'd18);
        reg_rd(REG_RESULT, d); check("result", d, {14'h0, target});
        @(posedge clock) convert_start_n <= 1'b1;
        wait_busy(1'b1, 80, k); check("no start while high", busy, 32'h0);
        @(posedge clock) convert_start_n <= 1'b0;
        wait_busy(1'b1, 8, k); check("start on falling edge", busy, 32'h1);
        wait_busy(1'b0, 30, k);
        @(posedge clock) begin cs_n <= 1'b0; rd_n <= 1'b0; end
        for (int i = 0; i < 32; i++) begin
            @(posedge clock) begin
                {bus_format_sel_hi, bus_format_sel_lo} <= i[4:3];
                host_pins <= {15'h0, i[2:0]};
            end
            // select pins settle only after the previous format releases them
            cyc(7);
            #1 e = exp_bus(i[4:3], i[1], i[2], i[0]);
            check("bus enables", data_oe, e[35:18]);
            check("bus data", data_out & data_oe, e[17:0]);
        end
        @(posedge clock) begin cs_n <= 1'b1; {bus_format_sel_hi, bus_format_sel_lo} <= FMT_PAR18; end
        cyc(5); #1 check("bus released", data_oe, 32'h0);
        wait_busy(1'b1, 80, k);
        wait_busy(1'b0, 30, k);
        wait_busy(1'b1, 80, k); check("acquisition length", k, ACQ_CYC);
        @(posedge clock) power_down_in <= 1'b1;
        cyc(8); #1 check("finish under power-down", busy, 32'h1);
        wait_busy(1'b0, 30, k); check("finished under power-down", busy, 32'h0);
        wait_busy(1'b1, 100, k); check("no start in power-down", busy, 32'h0);
        check("low power", low_power, 32'h1);
        reg_rd(REG_STATUS, d); check("status in power-down", d, 32'ha);
        @(posedge clock) power_down_in <= 1'b0;
        wait_busy(1'b1, 80, k);
        cyc(5);
        @(posedge clock) reset <= 1'b1;
        cyc(3);
        #1 check("abort busy", busy, 32'h0);
        check("abort hold", sample_hold, 32'h0);
        @(posedge clock) reset <= 1'b0;
        give_verdict();
    end
endmodule // testbench
